// [iadc_pkg.sv]
// Package for the I2C readable converter port: addresses, widths, states.
// Assumes one 200 MHz clock domain and an I2C bus sampled synchronously.
package iadc_pkg;
  localparam int          DATA_W        = 8;
  localparam logic [6:0]  SLAVE_ADDR    = 7'h00;
  localparam logic [7:0]  CTRL_OFFSET   = 8'hF4;
  localparam logic [7:0]  LEVELS_OFFSET = 8'hF6;
  localparam logic [7:0]  CTRL_RESET    = 8'h01;
  localparam int          PWR_DOWN_BIT  = 0;
  localparam logic [7:0]  CAP_RESET     = 8'h00;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;
  localparam logic [3:0]  LAST_BIT      = 4'h7;
  localparam logic [7:0]  GAIN_ON_RESET = 8'h01;
  localparam logic        OUT_EN_RESET  = 1'b1;

  typedef enum logic [2:0] {
    IADC_IDLE = 3'b000,
    IADC_ADDR = 3'b001,
    IADC_AACK = 3'b011,
    IADC_WBYT = 3'b010,
    IADC_WACK = 3'b110,
    IADC_RBYT = 3'b111,
    IADC_RACK = 3'b101
  } iadc_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } iadc_i2c_t;
endpackage : iadc_pkg

// [iadc_top.sv]
// I2C readable converter port: capture stage plus I2C bridge.
// Assumes SCL/SDA already synchronous to clk_in; SDA is open drain.
// Notes on behaviour
// - Each conversion yields 8 bits, driven together on eight parallel lines.
// - Capture stage updates once per conversion-complete event.
// - Gain stage powered on and parallel output enabled, else no data out.
// - Bit 0 of the writable control byte drives the converter power-down line.
// - Reading byte parallel_input_levels returns the eight parallel lines, bit 0 lowest.
`timescale 1ns/100ps
`default_nettype none
module iadc_top (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic [7:0] conv_result_in,
  input  wire logic       conv_done_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  output logic            power_down_line_out,
  output logic [7:0]      parallel_lines_out
);
  iadc_pkg::iadc_i2c_t bus_now;
  iadc_pkg::iadc_i2c_t bus_reg;
  iadc_pkg::iadc_i2c_t bus_next;
  iadc_pkg::iadc_state_t state_reg, state_next;
  logic [7:0] cap_reg, cap_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] gain_reg, gain_next;
  logic       out_en_reg, out_en_next;
  logic       sda_reg, sda_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] ptr_reg, ptr_next;
  logic [3:0] cnt_reg, cnt_next;
  logic       rw_reg, rw_next;
  logic       ptr_ok_reg, ptr_ok_next;
  logic       oe_reg, oe_next;
  logic       start_c, stop_c, rise_c, fall_c;

  assign bus_now.scl = scl_in;
  assign bus_now.sda = sda_in;
  assign start_c = bus_reg.scl && bus_now.scl && bus_reg.sda && !bus_now.sda;
  assign stop_c  = bus_reg.scl && bus_now.scl && !bus_reg.sda && bus_now.sda;
  assign rise_c  = !bus_reg.scl && bus_now.scl;
  assign fall_c  = bus_reg.scl && !bus_now.scl;

  // Capture stage: fixed configuration, gain on and output enabled
  always_comb begin
    cap_next = cap_reg;
    if (conv_done_in && gain_reg[0] && out_en_reg) begin
      cap_next = conv_result_in;
    end
  end

  // Bridge state machine
  always_comb begin
    state_next  = state_reg;
    shift_next  = shift_reg;
    ptr_next    = ptr_reg;
    cnt_next    = cnt_reg;
    rw_next     = rw_reg;
    ptr_ok_next = ptr_ok_reg;
    ctrl_next   = ctrl_reg;
    oe_next     = oe_reg;
    if (start_c) begin
      state_next = iadc_pkg::IADC_ADDR;
      cnt_next   = 4'h0;
      oe_next    = 1'b0;
    end else if (stop_c) begin
      state_next  = iadc_pkg::IADC_IDLE;
      oe_next     = 1'b0;
    end else begin
      case (state_reg)
        iadc_pkg::IADC_ADDR: begin
          if (rise_c) begin
            shift_next = {shift_reg[6:0], bus_now.sda};
            cnt_next   = cnt_reg + 4'h1;
          end else if (fall_c && cnt_reg == iadc_pkg::BYTE_BITS) begin
            if (shift_reg[7:1] == iadc_pkg::SLAVE_ADDR) begin
              rw_next     = shift_reg[0];
              ptr_ok_next = 1'b0;
              oe_next     = 1'b1;
              state_next  = iadc_pkg::IADC_AACK;
            end else begin
              state_next = iadc_pkg::IADC_IDLE;
            end
          end
        end
        iadc_pkg::IADC_AACK, iadc_pkg::IADC_WACK: begin
          if (fall_c) begin
            cnt_next = 4'h0;
            if (rw_reg) begin
              // Pins sampled at shift time, no holding register
              shift_next = (ptr_reg == iadc_pkg::LEVELS_OFFSET) ?
                           cap_reg : 8'h00;
              oe_next    = (ptr_reg == iadc_pkg::LEVELS_OFFSET) ?
                           !cap_reg[7] : 1'b1;
              state_next = iadc_pkg::IADC_RBYT;
            end else begin
              oe_next    = 1'b0;
              state_next = iadc_pkg::IADC_WBYT;
            end
          end
        end
        iadc_pkg::IADC_WBYT: begin
          if (rise_c) begin
            shift_next = {shift_reg[6:0], bus_now.sda};
            cnt_next   = cnt_reg + 4'h1;
          end else if (fall_c && cnt_reg == iadc_pkg::BYTE_BITS) begin
            if (!ptr_ok_reg) begin
              ptr_next    = shift_reg;
              ptr_ok_next = 1'b1;
            end else begin
              if (ptr_reg == iadc_pkg::CTRL_OFFSET) begin
                ctrl_next = shift_reg;
              end
              ptr_next = ptr_reg + 8'h01;
            end
            oe_next    = 1'b1;
            state_next = iadc_pkg::IADC_WACK;
          end
        end
        iadc_pkg::IADC_RBYT: begin
          if (fall_c) begin
            if (cnt_reg == iadc_pkg::LAST_BIT) begin
              oe_next    = 1'b0;
              ptr_next   = ptr_reg + 8'h01;
              state_next = iadc_pkg::IADC_RACK;
            end else begin
              cnt_next   = cnt_reg + 4'h1;
              shift_next = {shift_reg[6:0], 1'b0};
              oe_next    = !shift_reg[6];
            end
          end
        end
        iadc_pkg::IADC_RACK: begin
          // Host NACK ends the read; ACK sends the next byte
          if (rise_c) begin
            state_next = bus_now.sda ? iadc_pkg::IADC_IDLE : iadc_pkg::IADC_AACK;
          end
        end
        default: begin
          oe_next = 1'b0;
        end
      endcase
    end
  end

  // Fixed configuration: no writable path, so it cannot be left off
  always_comb begin
    gain_next   = gain_reg;
    out_en_next = out_en_reg;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gain_reg   <= iadc_pkg::GAIN_ON_RESET;
      out_en_reg <= iadc_pkg::OUT_EN_RESET;
    end else begin
      gain_reg   <= gain_next;
      out_en_reg <= out_en_next;
    end
  end

  // Previous pin levels; idle high after reset avoids a false START
  always_comb begin
    bus_next = bus_now;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bus_reg <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      bus_reg <= bus_next;
    end
  end

  // Capture stage register
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cap_reg <= iadc_pkg::CAP_RESET;
    end else begin
      cap_reg <= cap_next;
    end
  end

  // Bridge registers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg  <= iadc_pkg::IADC_IDLE;
      ctrl_reg   <= iadc_pkg::CTRL_RESET;
      shift_reg  <= 8'h00;
      ptr_reg    <= 8'h00;
      cnt_reg    <= 4'h0;
      rw_reg     <= 1'b0;
      ptr_ok_reg <= 1'b0;
      oe_reg     <= 1'b0;
    end else begin
      state_reg  <= state_next;
      ctrl_reg   <= ctrl_next;
      shift_reg  <= shift_next;
      ptr_reg    <= ptr_next;
      cnt_reg    <= cnt_next;
      rw_reg     <= rw_next;
      ptr_ok_reg <= ptr_ok_next;
      oe_reg     <= oe_next;
    end
  end

  // Open drain: the data value is always low, only the enable moves
  always_comb begin
    sda_next = 1'b0;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sda_reg <= 1'b0;
    end else begin
      sda_reg <= sda_next;
    end
  end

  assign sda_out             = sda_reg;
  assign sda_oe_out          = oe_reg;
  assign power_down_line_out = ctrl_reg[iadc_pkg::PWR_DOWN_BIT];
  assign parallel_lines_out  = cap_reg;
endmodule : iadc_top
`default_nettype wire

// [iadc_props.sv]
// Checker for the converter port pins.
// Bound to iadc_top; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module iadc_props (
  input wire logic       clk_in,
  input wire logic       reset_n_in,
  input wire logic [7:0] conv_result_in,
  input wire logic       conv_done_in,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_out,
  input wire logic       power_down_line_out,
  input wire logic [7:0] parallel_lines_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  cap_load_a: assert property (conv_done_in |=>
    parallel_lines_out == $past(conv_result_in)) else $error("capture lost");
  cap_hold_a: assert property (!conv_done_in |=>
    $stable(parallel_lines_out)) else $error("lines moved");
  out_live_a: assert property (conv_done_in && conv_result_in != 8'h00 |=>
    parallel_lines_out != 8'h00) else $error("output dead");
  pwr_edge_a: assert property ($changed(power_down_line_out) |->
    !scl_in) else $error("power-down moved with scl high");
  sda_edge_a: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("sda moved with scl high");
  sda_od_a: assert property (sda_oe_out |-> !sda_out) else $error("sda not low");
  cover property (conv_done_in);
  cover property ($fell(power_down_line_out));
  cover property ($rose(sda_oe_out));
endmodule : iadc_props
bind iadc_top iadc_props props (.clk_in, .reset_n_in, .conv_result_in, .conv_done_in,
  .scl_in, .sda_in, .sda_out, .sda_oe_out, .power_down_line_out, .parallel_lines_out);
`default_nettype wire

// [iadc_host.sv]
// I2C host model: framing and byte transfers.
// SDA resolved outside; moves just after rising edges.
`timescale 1ns/100ps
`default_nettype none
module iadc_host (
  input  wire logic clk,
  input  wire logic sda,
  output var logic  scl,
  output var logic  sda_drv
);
  initial {scl, sda_drv} = 2'b11;
  // Three (scl, sda) phases of four cycles each
  task automatic seq(input logic [5:0] s);
    for (int i = 2; i >= 0; i--) begin
      scl <= s[2*i+1];
      sda_drv <= s[2*i];
      repeat (4) @(posedge clk);
    end
  endtask : seq
  // Data moves only with scl low, sampled late in high phase
  task automatic xfer(input logic [8:0] b, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      seq({1'b0, sda_drv, 1'b0, b[i], 1'b1, b[i]});
      r[i] = sda;
    end
  endtask : xfer
  task automatic acc(input logic [7:0] a, d, input logic rd, output logic [8:0] r);
    logic [8:0] k;
    seq(6'h3E);
    xfer({iadc_pkg::SLAVE_ADDR, 2'b01}, k);
    xfer({a, 1'b1}, r);
    if (rd) begin
      seq(6'h1E);
      xfer({iadc_pkg::SLAVE_ADDR, 2'b11}, k);
    end
    xfer(rd ? 9'h1FF : {d, 1'b1}, r);
    seq(6'h0B);
  endtask : acc
endmodule : iadc_host
`default_nettype wire

// [tb.sv]
// Bench: host model on I2C, bench pulses conversions.
// Needs iadc_top, iadc_host and the checker.
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int WAIT_CYC = 40; // Short stand-in for the 600 us wait
  logic       clk_in = 1'b0;
  logic       reset_n_in = 1'b0;
  logic       conv_done_in = 1'b0;
  logic [7:0] conv_result_in = 8'h00;
  logic [7:0] e;
  logic [8:0] r;
  int         mismatches = 0;
  int         comparisons = 0;
  int         cyc = 0;
  logic [7:0] exp_q[$];
  logic       exp_pwr = 1'b1;
  wire logic  scl_in, sda_drv, sda_out, sda_oe_out, power_down;
  wire logic [7:0] lines;
  wire logic  sda_in = sda_oe_out ? (sda_drv & sda_out) : sda_drv;
  iadc_top uut (.clk_in, .reset_n_in, .conv_result_in, .conv_done_in, .scl_in, .sda_in,
    .sda_out, .sda_oe_out, .power_down_line_out(power_down), .parallel_lines_out(lines));
  iadc_host host (.clk(clk_in), .sda(sda_in), .scl(scl_in), .sda_drv);
  always #2.5 clk_in = ~clk_in;
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    comparisons++;
    if (g !== x) begin
      mismatches++;
      $display("wrong value %0t: got %h want %h", $time, g, x);
    end
  endtask : chk
  task automatic conv(input logic [7:0] v);
    exp_q.push_back(v);
    conv_result_in <= v;
    conv_done_in <= 1'b1;
    @(posedge clk_in);
    conv_done_in <= 1'b0;
    conv_result_in <= 8'($urandom);
    @(posedge clk_in);
  endtask : conv
  task automatic results;
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    void'($urandom(32'h53E25410));
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    chk({7'h00, power_down}, iadc_pkg::CTRL_RESET);
    host.acc(8'hF5, 8'h00, 1'b0, r);
    chk({6'h00, r[0], power_down}, {7'h00, exp_pwr});
    for (int i = 0; i < 6; i++) begin
      host.acc(iadc_pkg::CTRL_OFFSET, 8'h00, 1'b0, r);
      exp_pwr = 1'b0;
      chk({6'h00, r[0], power_down}, {7'h00, exp_pwr});
      e = i == 0 ? 8'hFF : (i == 1 ? 8'h00 : 8'($urandom));
      conv(e);
      chk(lines, exp_q[$]);
      repeat (WAIT_CYC) @(posedge clk_in);
      chk(lines, exp_q[$]);
      host.acc(iadc_pkg::LEVELS_OFFSET, 8'h00, 1'b1, r);
      chk(r[8:1], exp_q[$]);
      e = ~e;
      fork
        host.acc(iadc_pkg::LEVELS_OFFSET, 8'h00, 1'b1, r);
        conv_late(e);
      join
      chk(r[8:1], exp_q[$]);
      host.acc(iadc_pkg::CTRL_OFFSET, 8'h01, 1'b0, r);
      exp_pwr = 1'b1;
      chk({6'h00, r[0], power_down}, {7'h00, exp_pwr});
      repeat (WAIT_CYC) @(posedge clk_in);
    end
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    exp_q.push_back(iadc_pkg::CAP_RESET);
    chk(lines, exp_q[$]);
    chk({7'h00, power_down}, iadc_pkg::CTRL_RESET);
    reset_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    host.acc(8'hF5, 8'h00, 1'b1, r);
    chk(r[8:1], 8'h00);
    results();
  end
  // New result lands before the data byte starts shifting
  task automatic conv_late(input logic [7:0] v);
    repeat (60) @(posedge clk_in);
    conv(v);
  endtask : conv_late
endmodule : tb
`default_nettype wire
